// >>> core/eir_router.sv
// external interrupt input, priority and routing logic
// How it works
// RULE1 - nmi is top priority, level detected
// RULE2 - each external input owns its level
// RULE3 - lower four go to host or core
// RULE4 - devices request by driving line low
// RULE5 - host line asserted when attention needed
// RULE6 - host lines need no pci clock alignment
// RULE7 - host line held until driver clears
// RULE8 - host lines are level sensitive
// RULE9 - route select per line, core after reset
module eir_router (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_nmi_n,
  input  wire logic [3:0] i_ext_irq_lower_n,
  input  wire logic [3:0] i_ext_irq_upper_n,
  input  wire logic [3:0] i_route_host,
  input  wire logic [3:0] i_host_clear,
  output logic      [3:0] o_host_irq_line_n,
  output logic      [3:0] o_host_irq_line_oe,
  output logic      [7:0] o_core_irq,
  output logic            o_core_nmi,
  output logic      [3:0] o_core_level
);
  logic       rst_meta_q;
  logic       rst_sync_q;
  logic [8:0] pins_s;
  logic [3:0] route_q;
  logic [3:0] route_d;
  logic [3:0] pend_q;
  logic [3:0] pend_d;
  logic [3:0] line_n_q;
  logic [3:0] line_n_d;
  logic [7:0] core_q;
  logic [7:0] core_d;
  logic       nmi_q;
  logic       nmi_d;
  logic [3:0] lvl_q;
  logic [3:0] lvl_d;
  logic       rst_seen_q;

  // reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // pins are asynchronous, idle high
  eir_sync #(.W(9), .RST_VAL(9'h1ff)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_sync_q),
    .i_async   ({i_nmi_n, i_ext_irq_upper_n, i_ext_irq_lower_n}),
    .o_sync    (pins_s)
  );

  // highest active core-routed external input wins a level; nmi overrides all
  function automatic logic [3:0] prio_level(input logic [7:0] req);
    logic [3:0] lvl;
    lvl = eir_pkg::NO_LEVEL;
    for (int k = 0; k < eir_pkg::NUM_EXT; k++) begin
      if (req[k]) lvl = 4'(k + 1);
    end
    return lvl;
  endfunction

  always_comb begin
    logic [7:0] req;
    req     = ~pins_s[7:0]; // RULE4
    route_d = rst_seen_q ? i_route_host : eir_pkg::ROUTE_RST; // RULE9
    nmi_d   = ~pins_s[8]; // RULE1
    core_d  = req; // RULE2
    pend_d  = pend_q & ~i_host_clear; // RULE7
    for (int k = 0; k < eir_pkg::NUM_LOWER; k++) begin
      if (route_q[k] == eir_pkg::EIR_ROUTE_HOST) begin
        core_d[k] = 1'b0; // RULE3
        if (req[k]) pend_d[k] = 1'b1; // RULE5
      end else begin
        pend_d[k] = 1'b0;
      end
    end
    lvl_d = nmi_d ? eir_pkg::NMI_LEVEL : prio_level(core_d); // RULE1
    line_n_d = ~pend_d; // RULE8
  end

  // route select taken only after reset release, so reset forces core
  always_ff @(posedge i_ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rst_seen_q <= 1'b0;
      route_q    <= eir_pkg::ROUTE_RST; // RULE9
      pend_q     <= 4'h0;
      line_n_q   <= eir_pkg::HOST_IRQ_RST_N;
      core_q     <= eir_pkg::CORE_IRQ_RST;
      nmi_q      <= 1'b0;
      lvl_q      <= eir_pkg::NO_LEVEL;
    end else begin
      rst_seen_q <= 1'b1;
      route_q    <= route_d;
      pend_q     <= pend_d;
      line_n_q   <= line_n_d;
      core_q     <= core_d;
      nmi_q      <= nmi_d;
      lvl_q      <= lvl_d;
    end
  end

  // open drain: low only while driven; no pci clock involved
  assign o_host_irq_line_n  = line_n_q; // RULE6 RULE8
  assign o_host_irq_line_oe = pend_q;
  assign o_core_irq         = core_q;
  assign o_core_nmi         = nmi_q;
  assign o_core_level       = lvl_q;

  property p_nmi_level;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      !pins_s[8] |=> (o_core_nmi && o_core_level == eir_pkg::NMI_LEVEL);
  endproperty
  a_nmi_level: assert property (p_nmi_level) else $error("nmi not top level"); // RULE1

  property p_upper_ded;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      1'b1 |=> o_core_irq[7:4] == ~$past(pins_s[7:4]);
  endproperty
  a_upper_ded: assert property (p_upper_ded) else $error("upper line not mapped"); // RULE2

  property p_route_excl;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      (o_core_irq[3:0] & pend_q) == 4'h0;
  endproperty
  a_route_excl: assert property (p_route_excl) else $error("line routed twice"); // RULE3

  sequence s_host_req;
    route_q[2] && !pins_s[2];
  endsequence
  property p_host_assert;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      s_host_req |=> !o_host_irq_line_n[2] && o_host_irq_line_oe[2];
  endproperty
  a_host_assert: assert property (p_host_assert) else $error("host line not asserted"); // RULE5

  property p_hold;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      1'b1 |=> (o_host_irq_line_n & ~$past(o_host_irq_line_n) & ~$past(i_host_clear)
        & $past(route_q)) == 4'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("host line dropped early"); // RULE7

  property p_oe_match;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      o_host_irq_line_oe == ~o_host_irq_line_n;
  endproperty
  a_oe_match: assert property (p_oe_match) else $error("enable and level differ"); // RULE8

  property p_core_route;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      (!route_q[2] && !pins_s[2]) |=> o_core_irq[2] && o_host_irq_line_n[2];
  endproperty
  a_core_route: assert property (p_core_route) else $error("core route broken"); // RULE9

  property p_reset_core;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      $rose(rst_seen_q) |-> route_q == eir_pkg::ROUTE_RST;
  endproperty
  a_reset_core: assert property (p_reset_core) else $error("route not core after reset"); // RULE9

  property p_nmi_drop;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      pins_s[8] |=> !o_core_nmi;
  endproperty
  a_nmi_drop: assert property (p_nmi_drop) else $error("nmi held without request"); // RULE1

  property p_level_upper;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      (pins_s[8] && !pins_s[7]) |=> o_core_level == 4'(eir_pkg::NUM_EXT);
  endproperty
  a_level_upper: assert property (p_level_upper) else $error("top input level wrong"); // RULE2

  property p_level_lowest;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      (pins_s == 9'h1fe && !route_q[0]) |=> o_core_level == 4'h1;
  endproperty
  a_level_lowest: assert property (p_level_lowest) else $error("input zero level wrong"); // RULE2

  property p_level_idle;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      (pins_s == 9'h1ff) |=> (o_core_level == eir_pkg::NO_LEVEL && o_core_irq == 8'h00);
  endproperty
  a_level_idle: assert property (p_level_idle) else $error("level without request"); // RULE2

  property p_core_follow;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      1'b1 |=> o_core_irq[3:0] == (~$past(pins_s[3:0]) & ~$past(route_q));
  endproperty
  a_core_follow: assert property (p_core_follow) else $error("lower core line wrong"); // RULE2 RULE3

  property p_clear_release;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      (i_host_clear[2] && pins_s[2]) |=> o_host_irq_line_n[2] && !o_host_irq_line_oe[2];
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("host line not freed"); // RULE7

  // set wins: a clear racing a live request is lost, driver must clear again
  sequence s_clear_race;
    route_q[2] && !pins_s[2] && i_host_clear[2];
  endsequence
  property p_set_wins;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      s_clear_race |=> !o_host_irq_line_n[2];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat live request"); // RULE7

  // rerouting to core drops the host line, so a stale request cannot hang the host
  property p_reroute_release;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      !route_q[3] |=> o_host_irq_line_n[3] && !o_host_irq_line_oe[3];
  endproperty
  a_reroute_release: assert property (p_reroute_release) else $error("host line on core route"); // RULE9

  property p_route_take;
    @(posedge i_ref_clk) disable iff (!rst_sync_q)
      rst_seen_q |=> route_q == $past(i_route_host);
  endproperty
  a_route_take: assert property (p_route_take) else $error("route select not taken"); // RULE9
endmodule

// >>> core/eir_pkg.sv
// constants shared by the external interrupt router
package eir_pkg;
  localparam int          NUM_LOWER      = 4;
  localparam int          NUM_UPPER      = 4;
  localparam int          NUM_EXT        = NUM_LOWER + NUM_UPPER;
  localparam int          LVL_W          = 4;
  localparam int          SYNC_STAGES    = 2;
  localparam logic [3:0]  ROUTE_RST      = 4'h0;
  localparam logic [3:0]  HOST_IRQ_RST_N = 4'hf;
  localparam logic [7:0]  CORE_IRQ_RST   = 8'h00;
  localparam logic [3:0]  NMI_LEVEL      = 4'hf;
  localparam logic [3:0]  NO_LEVEL       = 4'h0;
  typedef enum logic {EIR_ROUTE_CORE, EIR_ROUTE_HOST} eir_route_t;
endpackage

// >>> core/eir_sync.sv
// two-flop synchroniser bank with a constant reset value
module eir_sync #(
  parameter int         W       = 8,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule

// >>> tb/eir_dev_model.sv
// interrupting devices and host driver stand-in
module eir_dev_model (
  input  wire logic       i_ref_clk,
  input  wire logic [8:0] i_req,
  input  wire logic [3:0] i_host_wire_n,
  output logic            o_nmi_n,
  output logic      [7:0] o_ext_n,
  output logic      [3:0] o_host_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_nmi_n = ~i_req[8];
  assign o_ext_n = ~i_req[7:0];
  // driver clears only once the device is served
  // registered, so the clear moves only just after an edge
  always_ff @(posedge i_ref_clk) begin
    o_host_clear <= ~i_host_wire_n & ~i_req[3:0];
  end
endmodule

// >>> tb/eir_router_test.sv
// self-checking bench for the router
module eir_router_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [8:0] req = '0;
  logic [3:0] route = '0;
  logic       nmi_n, nmi;
  logic [7:0] ext_n, core;
  logic [3:0] clr, line_n, oe, lvl, wire_n;
  int bad_count = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  // open drain with pull-up
  assign wire_n = line_n | ~oe;
  eir_dev_model dev_u (.i_ref_clk(clk), .i_req(req), .i_host_wire_n(wire_n),
    .o_nmi_n(nmi_n), .o_ext_n(ext_n), .o_host_clear(clr));
  eir_router dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_nmi_n(nmi_n),
    .i_ext_irq_lower_n(ext_n[3:0]), .i_ext_irq_upper_n(ext_n[7:4]),
    .i_route_host(route), .i_host_clear(clr), .o_host_irq_line_n(line_n),
    .o_host_irq_line_oe(oe), .o_core_irq(core), .o_core_nmi(nmi),
    .o_core_level(lvl));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic t_core();
    for (int k = 0; k < 8; k++) begin
      req = 9'h001 << k;
      tick(5);
      chk("core", 8'h01 << k, core);
      chk("level", 8'(k + 1), {4'h0, lvl});
      chk("host", 8'h0f, {4'h0, line_n});
      req = '0;
      tick(5);
    end
    req = 9'h00a;
    tick(5);
    chk("core", 8'h0a, core);
    chk("level", 8'h04, {4'h0, lvl});
    req = '0;
    tick(5);
    $display("core routing done");
  endtask
  task automatic t_nmi();
    req = 9'h180;
    tick(5);
    chk("level", 8'h0f, {4'h0, lvl});
    // level detect: no re-edge, still held
    tick(40);
    chk("nmi", 8'h01, {7'h0, nmi});
    req = '0;
    tick(5);
    chk("nmi", 8'h00, {7'h0, nmi});
    $display("nmi done");
  endtask
  task automatic t_host();
    route = 4'hf;
    req = 9'h004;
    tick(5);
    chk("host", 8'h0b, {4'h0, line_n});
    chk("oe", 8'h04, {4'h0, oe});
    chk("core", 8'h00, core);
    tick(40);
    chk("host", 8'h0b, {4'h0, wire_n});
    req = '0;
    for (int i = 0; i < 12 && wire_n[2] !== 1'b1; i++) tick(1);
    chk("host", 8'h0f, {4'h0, wire_n});
    chk("oe", 8'h00, {4'h0, oe});
    route = '0;
    $display("host routing done");
  endtask
  task automatic t_reset();
    rst_n = 1'b1;
    tick(4);
    chk("host", 8'h0f, {4'h0, line_n});
    chk("oe", 8'h00, {4'h0, oe});
    chk("core", 8'h00, core);
    chk("nmi", 8'h00, {7'h0, nmi});
    $display("reset done");
  endtask
  task automatic t_reroute();
    tick(2);
    route = 4'h8;
    req = 9'h008;
    tick(5);
    chk("host", 8'h07, {4'h0, wire_n});
    chk("core", 8'h00, core);
    route = '0;
    tick(5);
    chk("host", 8'h0f, {4'h0, wire_n});
    chk("oe", 8'h00, {4'h0, oe});
    chk("core", 8'h08, core);
    chk("level", 8'h04, {4'h0, lvl});
    req = '0;
    tick(5);
    $display("reroute done");
  endtask
  initial begin
    tick(20);
    t_reset();
    t_core();
    t_nmi();
    t_host();
    t_reroute();
    tally_and_finish();
  end
endmodule
